// ===== common/loop_port_pkg.sv
// package: constants and carrier types for the loop converter serial update port
package loop_port_pkg;
  // serial word width
  localparam int word_bits = 24;
  localparam logic [4:0] word_bits_m1 = 5'h17;
  localparam logic [4:0] count_reset = 5'h00;
  localparam logic [23:0] word_reset = 24'h000000;
  // top of the host serial clock rate, kept as printed in MHz
  localparam int sclk_max_mhz = 30;
  localparam int pclk_mhz = 200;
  // least pclk cycles per serial clock half period
  localparam int sclk_half_cycles = pclk_mhz / (2 * sclk_max_mhz);

  // apb register byte offsets
  localparam logic [7:0] status_off = 8'h00;
  localparam logic [7:0] mask_off = 8'h04;
  localparam logic [7:0] input_word_off = 8'h08;
  localparam logic [7:0] output_word_off = 8'h0c;
  localparam logic [7:0] readback_off = 8'h10;
  localparam logic [7:0] straps_off = 8'h14;
  localparam logic [7:0] fault_src_off = 8'h18;

  // status bit positions
  localparam int ev_write_bit = 0;
  localparam int ev_update_bit = 1;
  localparam int ev_fault_bit = 2;
  localparam logic [2:0] status_reset = 3'h0;
  localparam logic [2:0] mask_reset = 3'h0;
  localparam logic [4:0] fault_reset = 5'h00;

  // fault source bit positions in the fault source word
  localparam int flt_link_bit = 0;
  localparam int flt_crc_bit = 1;
  localparam int flt_current_bit = 2;
  localparam int flt_voltage_bit = 3;
  localparam int flt_temp_bit = 4;

  // serial pins after synchronising
  typedef struct packed {
    logic sclk;
    logic frame_n;
    logic serial_in;
    logic load_output_n;
  } link_pins_t;

  // static strap levels
  typedef struct packed {
    logic alarm_upscale;
    logic resistor_internal;
    logic [1:0] span;
    logic [2:0] regulator;
  } straps_t;
endpackage : loop_port_pkg

// ===== rtl/sync_two_ff.sv
// file: two flip-flop synchroniser for one level
`timescale 1ns/100ps
module sync_two_ff #(
  parameter logic reset_value = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= reset_value;
      sync_out <= reset_value;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // sync_two_ff

// ===== rtl/loop_dac_serial_update_port.sv
// file: serial update port, fault alert and strap decode of the loop converter
// Operation
// - shift readback out on rising serial clock
// - capture input bit on falling serial clock
// - bits move only while frame select low
// - frame select rising latches the write word
// - load tied low updates output at frame end
// - load high defers output until load falls
// - alert high while any fault, else low
// - five fault sources raise the alert
// - alarm strap picks upscale or downscale current
// - resistor strap picks internal or external resistor
// - two span straps decode the current range
// - three regulator straps jointly pick voltage
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module loop_dac_serial_update_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link pins
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_in,
  input wire logic load_output_n,
  output logic serial_out,
  output logic serial_out_oe,
  // fault sources from the analog side
  input wire logic packet_error_check,
  input wire logic current_out_of_range,
  input wire logic loop_voltage_low,
  input wire logic over_temperature,
  input wire logic link_watchdog_expired,
  // straps
  input wire logic alarm_direction_strap,
  input wire logic resistor_select_strap,
  input wire logic span_strap_0,
  input wire logic span_strap_1,
  input wire logic regulator_strap_0,
  input wire logic regulator_strap_1,
  input wire logic regulator_strap_2,
  // decoded outputs
  output logic fault_alert,
  output logic alarm_upscale,
  output logic resistor_internal,
  output logic [1:0] span_select,
  output logic [2:0] regulator_select,
  output logic [23:0] output_word,
  output logic irq
);
  loop_port_pkg::link_pins_t pins_raw, pins_s;
  loop_port_pkg::straps_t straps_raw, straps_s;
  logic sclk_prev_q, frame_prev_q, load_prev_q;
  logic sclk_rise, sclk_fall, frame_rise, load_fall;
  logic [23:0] shift_in_q, shift_out_q, input_word_q, output_word_q, readback_q;
  logic [4:0] bit_count_q, fault_q;
  logic pending_q, write_done, update_now;
  logic [2:0] status_q, mask_q, events;
  logic fault_prev_q;
  logic wr_en, rd_en;

  assign pins_raw = '{sclk: sclk, frame_n: frame_n, serial_in: serial_in, load_output_n: load_output_n};
  assign straps_raw = '{alarm_upscale: alarm_direction_strap, resistor_internal: resistor_select_strap,
                        span: {span_strap_1, span_strap_0},
                        regulator: {regulator_strap_2, regulator_strap_1, regulator_strap_0}};

  // every pin passes two flops; idle levels chosen so reset looks like no frame
  sync_two_ff #(.reset_value(1'b0)) sync_sclk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .async_in(pins_raw.sclk), .sync_out(pins_s.sclk));
  sync_two_ff #(.reset_value(1'b1)) sync_frame (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .async_in(pins_raw.frame_n), .sync_out(pins_s.frame_n));
  sync_two_ff #(.reset_value(1'b0)) sync_sdi (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .async_in(pins_raw.serial_in), .sync_out(pins_s.serial_in));
  sync_two_ff #(.reset_value(1'b1)) sync_load (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .async_in(pins_raw.load_output_n), .sync_out(pins_s.load_output_n));

  // straps go through the same synchroniser, sampled every cycle with no edge logic
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_strap
      sync_two_ff #(.reset_value(1'b0)) sync_strap (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .async_in(straps_raw[gi]), .sync_out(straps_s[gi]));
    end
  endgenerate

  // strap decode: pure levels, no latching on change
  assign alarm_upscale = straps_s.alarm_upscale;
  assign resistor_internal = straps_s.resistor_internal;
  assign span_select = straps_s.span;
  assign regulator_select = straps_s.regulator;

  // edge finders on synchronised pins; 200 MHz gives >=3 samples per 30 MHz half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= 1'b0;
      frame_prev_q <= 1'b1;
      load_prev_q <= 1'b1;
    end else if (clk_en) begin
      sclk_prev_q <= pins_s.sclk;
      frame_prev_q <= pins_s.frame_n;
      load_prev_q <= pins_s.load_output_n;
    end
  end

  assign sclk_rise = pins_s.sclk & ~sclk_prev_q & ~pins_s.frame_n;
  assign sclk_fall = ~pins_s.sclk & sclk_prev_q & ~pins_s.frame_n;
  assign frame_rise = pins_s.frame_n & ~frame_prev_q;
  assign load_fall = ~pins_s.load_output_n & load_prev_q;

  // input shift register: one bit per falling edge inside the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_in_q <= loop_port_pkg::word_reset;
      bit_count_q <= loop_port_pkg::count_reset;
    end else if (clk_en) begin
      if (sclk_fall) begin
        shift_in_q <= {shift_in_q[22:0], pins_s.serial_in};
        if (bit_count_q != loop_port_pkg::word_bits_m1) begin
          bit_count_q <= bit_count_q + 5'h01;
        end
      end else if (pins_s.frame_n) begin
        bit_count_q <= loop_port_pkg::count_reset;
      end
    end
  end

  // readback shifts out msb first; reloaded at frame start so bit 23 leads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_out_q <= loop_port_pkg::word_reset;
      serial_out <= 1'b0;
    end else if (clk_en) begin
      if (!pins_s.frame_n && frame_prev_q) begin
        shift_out_q <= readback_q;
      end else if (sclk_rise) begin
        serial_out <= shift_out_q[23];
        shift_out_q <= {shift_out_q[22:0], 1'b0};
      end
    end
  end
  // driven only inside a frame so the line is shared with other parts
  assign serial_out_oe = ~pins_s.frame_n;

  // write word latched when the frame closes
  assign write_done = frame_rise;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_word_q <= loop_port_pkg::word_reset;
    end else if (clk_en && write_done) begin
      input_word_q <= shift_in_q;
    end
  end

  // output update: immediate with load low at frame end, otherwise on load falling edge
  assign update_now = (write_done && !pins_s.load_output_n) || (load_fall && pending_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_word_q <= loop_port_pkg::word_reset;
      pending_q <= 1'b0;
    end else if (clk_en) begin
      if (write_done && !pins_s.load_output_n) begin
        output_word_q <= shift_in_q;
        pending_q <= 1'b0;
      end else if (write_done) begin
        pending_q <= 1'b1;
      end else if (load_fall && pending_q) begin
        output_word_q <= input_word_q;
        pending_q <= 1'b0;
      end
    end
  end
  assign output_word = output_word_q;

  // fault sources are sampled as levels; alert tracks them with two flops of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= loop_port_pkg::fault_reset;
      fault_alert <= 1'b0;
      fault_prev_q <= 1'b0;
    end else if (clk_en) begin
      fault_q[loop_port_pkg::flt_link_bit] <= link_watchdog_expired;
      fault_q[loop_port_pkg::flt_crc_bit] <= packet_error_check;
      fault_q[loop_port_pkg::flt_current_bit] <= current_out_of_range;
      fault_q[loop_port_pkg::flt_voltage_bit] <= loop_voltage_low;
      fault_q[loop_port_pkg::flt_temp_bit] <= over_temperature;
      fault_alert <= |fault_q;
      fault_prev_q <= fault_alert;
    end
  end

  // readback word carries the fault sources, refreshed every cycle outside a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback_q <= loop_port_pkg::word_reset;
    end else if (clk_en && pins_s.frame_n) begin
      readback_q <= {19'h00000, fault_q};
    end
  end

  // apb: zero wait states; unmapped offsets read zero with pslverr
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & clk_en;
  assign rd_en = psel & penable & ~pwrite;

  assign events = {fault_alert & ~fault_prev_q, update_now, write_done};

  // sticky status; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= loop_port_pkg::status_reset;
    end else if (clk_en) begin
      if (wr_en && paddr == loop_port_pkg::status_off) begin
        status_q <= (status_q & ~pwdata[2:0]) | events;
      end else begin
        status_q <= status_q | events;
      end
    end
  end

  // interrupt mask, one bit per status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= loop_port_pkg::mask_reset;
    end else if (wr_en && paddr == loop_port_pkg::mask_off) begin
      mask_q <= pwdata[2:0];
    end
  end
  assign irq = |(status_q & mask_q);

  // read mux and error answer
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (psel && penable) begin
      case (paddr)
        loop_port_pkg::status_off: prdata = {29'h00000000, status_q};
        loop_port_pkg::mask_off: prdata = {29'h00000000, mask_q};
        loop_port_pkg::input_word_off: prdata = {8'h00, input_word_q};
        loop_port_pkg::output_word_off: prdata = {8'h00, output_word_q};
        loop_port_pkg::readback_off: prdata = {8'h00, readback_q};
        loop_port_pkg::straps_off: prdata = {25'h0000000, straps_s};
        loop_port_pkg::fault_src_off: prdata = {27'h0000000, fault_q};
        default: pslverr = 1'b1;
      endcase
      if (!rd_en && paddr != loop_port_pkg::status_off && paddr != loop_port_pkg::mask_off) begin
        pslverr = 1'b1;
      end
    end
  end

  // frame, update and readback rules checked at the flops that carry them
  frame_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && frame_rise) |=> (input_word_q == $past(shift_in_q)))
    else $error("write word not latched at frame end");

  immediate_update_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && frame_rise && !pins_s.load_output_n) |=> (output_word_q == $past(shift_in_q)))
    else $error("output not updated with load held low");

  deferred_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && frame_rise && pins_s.load_output_n) |=> (output_word_q == $past(output_word_q)) && pending_q)
    else $error("output changed while load high");

  deferred_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && load_fall && pending_q && !frame_rise) |=> (output_word_q == $past(input_word_q)) && !pending_q)
    else $error("deferred update missing on load fall");

  capture_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sclk_fall) |=> (shift_in_q[0] == $past(pins_s.serial_in)))
    else $error("input bit not captured on falling edge");

  no_shift_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pins_s.frame_n && frame_prev_q) |=> (shift_in_q == $past(shift_in_q)))
    else $error("shift register moved outside frame");

  readback_shift_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sclk_rise && !(!pins_s.frame_n && frame_prev_q)) |=> (serial_out == $past(shift_out_q[23])))
    else $error("readback bit not driven on rising edge");

  alert_track_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en [*2]) |-> (fault_alert == $past(|fault_q)))
    else $error("alert does not follow fault sources");

  fault_sources_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && over_temperature) |=> fault_q[loop_port_pkg::flt_temp_bit])
    else $error("overtemperature not captured");

  strap_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en [*2]) |=> ((span_select == $past({span_strap_1, span_strap_0}, 2)) &&
      (regulator_select == $past({regulator_strap_2, regulator_strap_1, regulator_strap_0}, 2))))
    else $error("strap levels not passed through two flops");

  alarm_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en [*2]) |=> (alarm_upscale == $past(alarm_direction_strap, 2)))
    else $error("alarm direction strap not followed");

  resistor_strap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en [*2]) |=> (resistor_internal == $past(resistor_select_strap, 2)))
    else $error("resistor strap not followed");

  bit_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && pins_s.frame_n) |=> (bit_count_q == loop_port_pkg::count_reset))
    else $error("bit count not cleared outside frame");

  link_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && link_watchdog_expired) |=> fault_q[loop_port_pkg::flt_link_bit])
    else $error("link fault not captured");

  crc_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && packet_error_check) |=> fault_q[loop_port_pkg::flt_crc_bit])
    else $error("packet check fault not captured");

  current_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && current_out_of_range) |=> fault_q[loop_port_pkg::flt_current_bit])
    else $error("loop current fault not captured");

  voltage_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && loop_voltage_low) |=> fault_q[loop_port_pkg::flt_voltage_bit])
    else $error("loop voltage fault not captured");

  alert_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && fault_alert && !fault_prev_q) |=> status_q[loop_port_pkg::ev_fault_bit])
    else $error("alert rise not recorded in status");

  frame_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en [*2]) |=> (serial_out_oe == !$past(frame_n, 2)))
    else $error("readback driver enable outside frame");

  deferred_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && load_fall && !pending_q && !frame_rise) |=> $stable(output_word_q))
    else $error("load fall without pending write changed output");

  clock_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_en) |=> ($stable(output_word_q) && $stable(status_q) && $stable(shift_in_q)))
    else $error("state moved while clock enable low");

  refused_access_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr > loop_port_pkg::fault_src_off) |-> (pslverr && prdata == 32'h00000000))
    else $error("unmapped access not refused");
endmodule // loop_dac_serial_update_port

// ===== testbench/serial_host_model.sv
// host side serial controller model driving the link pins of the port
`timescale 1ns/100ps
module serial_host_model (
  output logic sclk,
  output logic frame_n,
  output logic serial_in,
  output logic load_output_n,
  input wire logic serial_out
);
  // 80 ns link clock, well below the host ceiling
  localparam time half_period = 40;

  // clock stands low and frame stays high outside frames
  initial begin
    sclk = 1'h0;
    frame_n = 1'h1;
    serial_in = 1'h0;
    load_output_n = 1'h1;
  end

  // one frame, msb first; data moves on the rising edge so it stands across the fall
  task automatic send(input logic [23:0] word, output logic [23:0] rb);
    frame_n = 1'h0;
    for (int i = 23; i >= 0; i--) begin
      #half_period sclk = 1'h1;
      serial_in = word[i];
      #half_period rb[i] = serial_out;
      sclk = 1'h0;
    end
    #half_period frame_n = 1'h1;
    // released line shows the inverse so a stale bit cannot pass
    serial_in = ~word[0];
    #half_period;
  endtask

  // load line level set by the bench scenarios
  task automatic set_load(input logic v);
    load_output_n <= v;
  endtask
endmodule // serial_host_model

// ===== testbench/loop_dac_serial_update_port_tb_top.sv
// self-checking bench for the loop converter serial update port
`timescale 1ns/100ps
module loop_dac_serial_update_port_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sclk, frame_n, serial_in, load_output_n, serial_out, serial_out_oe, fault_alert, irq, clk_en;
  logic alarm_upscale, resistor_internal;
  logic [1:0] span_select;
  logic [2:0] regulator_select;
  logic [23:0] output_word, rb;
  logic [6:0] straps_v;
  logic [4:0] flt_v;
  logic [6:0] pats [4] = '{7'h55, 7'h2a, 7'h7f, 7'h00};
  int failures, checks;

  // 200 MHz system clock
  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  // clock enable driven by the bench so the freeze can be exercised
  loop_dac_serial_update_port loop_dac_serial_update_port_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk(sclk), .frame_n(frame_n), .serial_in(serial_in), .load_output_n(load_output_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .link_watchdog_expired(flt_v[0]), .packet_error_check(flt_v[1]), .current_out_of_range(flt_v[2]),
    .loop_voltage_low(flt_v[3]), .over_temperature(flt_v[4]),
    .alarm_direction_strap(straps_v[6]), .resistor_select_strap(straps_v[5]),
    .span_strap_1(straps_v[4]), .span_strap_0(straps_v[3]), .regulator_strap_2(straps_v[2]),
    .regulator_strap_1(straps_v[1]), .regulator_strap_0(straps_v[0]),
    .fault_alert(fault_alert), .alarm_upscale(alarm_upscale), .resistor_internal(resistor_internal),
    .span_select(span_select), .regulator_select(regulator_select), .output_word(output_word), .irq(irq));

  serial_host_model serial_host_model_inst (.sclk(sclk), .frame_n(frame_n), .serial_in(serial_in),
    .load_output_n(load_output_n), .serial_out(serial_out));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    presetn = 1'h0;
    clk_en = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    straps_v = 7'h00;
    flt_v = 5'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    settle(1);
    check(fault_alert, 32'h0);
    check(serial_out_oe, 32'h0);
    // strap patterns must appear as plain levels on outputs and register
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      straps_v <= pats[i];
      settle(4);
      check({alarm_upscale, resistor_internal, span_select, regulator_select}, pats[i]);
      apb(1'h0, loop_port_pkg::straps_off, 32'h0);
      check(rd, pats[i]);
    end
    check({pready, err}, 32'h2);
    // each fault source alone raises and drops the alert
    apb(1'h1, loop_port_pkg::mask_off, 32'h7);
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      flt_v <= 5'h01 << i;
      settle(4);
      check(fault_alert, 32'h1);
      apb(1'h0, loop_port_pkg::fault_src_off, 32'h0);
      check(rd, 32'h1 << i);
      @(posedge pclk);
      flt_v <= 5'h00;
      settle(4);
      check(fault_alert, 32'h0);
    end
    // a low clock enable freezes the alert path; it catches up once enabled
    @(posedge pclk);
    clk_en <= 1'h0;
    flt_v <= 5'h04;
    settle(4);
    check(fault_alert, 32'h0);
    @(posedge pclk);
    clk_en <= 1'h1;
    settle(4);
    check(fault_alert, 32'h1);
    @(posedge pclk);
    flt_v <= 5'h00;
    settle(4);
    check(irq, 32'h1);
    apb(1'h1, loop_port_pkg::status_off, 32'h7);
    settle(2);
    check(irq, 32'h0);
    apb(1'h1, loop_port_pkg::mask_off, 32'h0);
    // immediate update with load low, readback of a live fault
    @(posedge pclk);
    flt_v <= 5'h10;
    serial_host_model_inst.set_load(1'h0);
    settle(4);
    serial_host_model_inst.send(24'ha5c3e1, rb);
    check(rb, 32'h10);
    settle(8);
    check(output_word, 32'ha5c3e1);
    apb(1'h0, loop_port_pkg::status_off, 32'h0);
    check(rd, 32'h7);
    // deferred update: load high during the frame, then a falling load edge
    serial_host_model_inst.set_load(1'h1);
    settle(4);
    serial_host_model_inst.send(24'h5a3c1e, rb);
    check(rb, 32'h10);
    settle(8);
    check(output_word, 32'ha5c3e1);
    apb(1'h0, loop_port_pkg::input_word_off, 32'h0);
    check(rd, 32'h5a3c1e);
    serial_host_model_inst.set_load(1'h0);
    settle(8);
    check(output_word, 32'h5a3c1e);
    // refused accesses leave the registers alone
    apb(1'h0, 8'h1c, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'h1, loop_port_pkg::input_word_off, 32'hffffff);
    check(err, 32'h1);
    apb(1'h0, loop_port_pkg::input_word_off, 32'h0);
    check(rd, 32'h5a3c1e);
    summarize();
  end

  // hang guard, some forty times the expected run length
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule // loop_dac_serial_update_port_tb_top
